// file: rtl/stc_pkg.sv
package stc_pkg;

  localparam logic [3:0] STC_OFS_LINK_CONTROL = 4'h4;
  localparam logic [3:0] STC_OFS_PROT_IDENT = 4'h4;
  localparam logic [3:0] STC_BANK_LINK_CONTROL = 4'h1;
  localparam logic [3:0] STC_BANK_PROT_IDENT = 4'h3;

  localparam int STC_TRN_LSB = 8;
  localparam int STC_TRN_MSB = 9;
  localparam int STC_LC_RES1_BIT = 6;
  localparam int STC_LC_RES0_LSB = 10;
  localparam logic [1:0] STC_TRN_RESET = 2'h0;

  localparam int STC_VSN_LSB = 0;
  localparam int STC_VSN_MSB = 3;
  localparam int STC_INST_LSB = 28;
  localparam int STC_INST_MSB = 31;
  localparam logic [3:0] STC_PROT_VSN_TWO = 4'h1;

  localparam int STC_SYNC_STAGES = 3;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [3:0] offset;
    logic [3:0] bank;
    logic [31:0] wdata;
  } stc_req_t;

  typedef struct packed
  {
    logic valid;
    logic hit;
    logic proto_err;
    logic [31:0] rdata;
  } stc_resp_t;

  typedef enum logic
  {
    STC_TRN_IDLE,
    STC_TRN_GAP
  } stc_trn_state_t;

  function automatic logic stc_addr_hit(input stc_req_t r,
                                        input logic [3:0] ofs,
                                        input logic [3:0] bank);
    stc_addr_hit = r.valid && (r.offset == ofs) && (r.bank == bank);
  endfunction

endpackage

// file: rtl/stc_edge_sampler.sv
`timescale 1ns/10ps
`default_nettype none
module stc_edge_sampler
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic async_in,
  output logic level_q,
  output logic rise_q
);

  logic [STC_SYNC_STAGES-1:0] sync_q;

  // First stage feeds only the second; decisions use stages two and three
  always_ff @(posedge clk)
  begin
    if (reset)
      sync_q <= '0;
    else if (ce)
      sync_q <= {sync_q[STC_SYNC_STAGES-2:0], async_in};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else if (ce)
    begin
      rise_q <= 1'b0;
      if (sync_q[1] == sync_q[2] && sync_q[2] != level_q)
      begin
        level_q <= sync_q[2];
        rise_q <= sync_q[2];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_rise_single: assert property (ce && rise_q |=> !rise_q)
    else $error("link edge pulse longer than one cycle");

endmodule
`default_nettype wire

// file: rtl/stc_link_turnaround_control.sv
// Summary of operation
// - Setting in link_control bits 9:8; codes 0..3 give 1..4 periods.
// - One turnaround unit is one link bit period, not internal clocks.
// - Fixed-turnaround build flags a setting change as protocol error.
// - link_control answers at offset 0x4 only with bank select 0x1.
// - Protocol ident only in architecture two; reports protocol version.
// - Architecture two port supports protocol version two with multi-drop.
// - Scan-chain variant: protocol ident is reserved with no content.
// - Protocol ident is 32 bits, content depends on link variant.
// - Scan link_control reads zero, ignores writes; bits 31:10 zero.
// - Ident bits 3:0 give protocol version; 0x1 means version two.
// - Ident bits 31:28 hold instance number; bits 27:4 read zero.
// - Protocol ident answers at offset 0x4 with bank select 0x3.
`timescale 1ns/10ps
`default_nettype none
module stc_link_turnaround_control
  import stc_pkg::*;
#(
  parameter bit VARIABLE_TRN = 1'b1,
  parameter bit SCAN_VARIANT = 1'b0,
  parameter bit ARCH_TWO = 1'b1,
  // Arbitrary default; must differ per target on a shared link
  parameter logic [3:0] INSTANCE_NUM = 4'h0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic link_clk,
  input wire stc_req_t req,
  input wire logic trn_start,
  output stc_resp_t resp,
  output logic [1:0] turnaround_length,
  output logic trn_active,
  output logic trn_done
);

  logic link_rise;
  logic hit_lc;
  logic hit_id;
  logic lc_wr;
  logic fixed_err;
  logic [1:0] len_q;
  logic [1:0] cnt_q;
  logic [31:0] lc_rdata;
  logic [31:0] id_rdata;
  stc_trn_state_t state_q;

  stc_edge_sampler u_link_sampler (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in(link_clk),
    .level_q(),
    .rise_q(link_rise)
  );

  assign hit_lc = stc_addr_hit(req, STC_OFS_LINK_CONTROL,
                               STC_BANK_LINK_CONTROL);
  // Reserved without architecture two: left for the port to answer
  assign hit_id = ARCH_TWO &&
                  stc_addr_hit(req, STC_OFS_PROT_IDENT,
                               STC_BANK_PROT_IDENT);
  assign lc_wr = hit_lc && req.write;
  assign fixed_err = lc_wr && !VARIABLE_TRN && !SCAN_VARIANT &&
    (req.wdata[STC_TRN_MSB:STC_TRN_LSB] != turnaround_length);

  always_ff @(posedge clk)
  begin
    if (reset)
      turnaround_length <= STC_TRN_RESET;
    else if (ce && lc_wr && VARIABLE_TRN && !SCAN_VARIANT)
      turnaround_length <= req.wdata[STC_TRN_MSB:STC_TRN_LSB];
  end

  always_comb
  begin
    lc_rdata = '0;
    if (!SCAN_VARIANT)
    begin
      lc_rdata[STC_TRN_MSB:STC_TRN_LSB] = turnaround_length;
      lc_rdata[STC_LC_RES1_BIT] = 1'b1;
    end
  end

  always_comb
  begin
    id_rdata = '0;
    if (!SCAN_VARIANT)
    begin
      id_rdata[STC_VSN_MSB:STC_VSN_LSB] = STC_PROT_VSN_TWO;
      id_rdata[STC_INST_MSB:STC_INST_LSB] = INSTANCE_NUM;
    end
  end

  // Answer one cycle after the request; writes answer with zero data
  always_ff @(posedge clk)
  begin
    if (reset)
      resp <= '0;
    else if (ce)
    begin
      resp.valid <= req.valid;
      resp.hit <= hit_lc || hit_id;
      resp.proto_err <= fixed_err;
      if (hit_lc && !req.write)
        resp.rdata <= lc_rdata;
      else if (hit_id && !req.write)
        resp.rdata <= id_rdata;
      else
        resp.rdata <= '0;
    end
  end

  // Gap counted in link clock edges so it tracks the wire rate
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= STC_TRN_IDLE;
      len_q <= STC_TRN_RESET;
      cnt_q <= '0;
      trn_active <= 1'b0;
      trn_done <= 1'b0;
    end
    else if (ce)
    begin
      trn_done <= 1'b0;
      unique case (state_q)
        STC_TRN_IDLE:
        begin
          if (trn_start)
          begin
            state_q <= STC_TRN_GAP;
            len_q <= turnaround_length;
            cnt_q <= '0;
            trn_active <= 1'b1;
          end
        end
        STC_TRN_GAP:
        begin
          if (link_rise)
          begin
            if (cnt_q == len_q)
            begin
              state_q <= STC_TRN_IDLE;
              trn_active <= 1'b0;
              trn_done <= 1'b1;
            end
            else
              cnt_q <= cnt_q + 2'd1;
          end
        end
      endcase
    end
  end

  // Helper for checks: link edges seen during the current gap
  logic [2:0] gap_edges_q;
  always_ff @(posedge clk)
  begin
    if (reset)
      gap_edges_q <= '0;
    else if (ce)
    begin
      if (!trn_active)
        gap_edges_q <= '0;
      else if (link_rise)
        gap_edges_q <= gap_edges_q + 3'd1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_len_write_taken: assert property (
    ce && lc_wr && VARIABLE_TRN && !SCAN_VARIANT |=>
      turnaround_length == $past(req.wdata[STC_TRN_MSB:STC_TRN_LSB]))
    else $error("turnaround setting not stored");
  chk_gap_edge_count: assert property (
    trn_done |-> gap_edges_q == {1'b0, len_q} + 3'd1)
    else $error("gap length differs from setting");
  chk_fixed_err: assert property (
    ce && lc_wr && !VARIABLE_TRN && !SCAN_VARIANT &&
      req.wdata[STC_TRN_MSB:STC_TRN_LSB] != turnaround_length |=>
      resp.proto_err && resp.valid && $stable(turnaround_length))
    else $error("fixed turnaround change not flagged");
  chk_lc_bank_miss: assert property (
    ce && req.valid && req.offset == STC_OFS_LINK_CONTROL &&
      req.bank != STC_BANK_LINK_CONTROL &&
      req.bank != STC_BANK_PROT_IDENT |=> resp.valid && !resp.hit)
    else $error("link control answered in wrong bank");
  chk_ident_version: assert property (
    ce && hit_id && !req.write && !SCAN_VARIANT |=>
      resp.rdata[STC_VSN_MSB:STC_VSN_LSB] == STC_PROT_VSN_TWO)
    else $error("protocol version field wrong");
  chk_ident_instance: assert property (
    ce && hit_id && !req.write && !SCAN_VARIANT |=>
      resp.rdata[STC_INST_MSB:STC_INST_LSB] == INSTANCE_NUM &&
      resp.rdata[STC_INST_LSB-1:STC_VSN_MSB+1] == '0)
    else $error("instance or reserved ident bits wrong");
  chk_scan_zero: assert property (
    SCAN_VARIANT && resp.valid |-> resp.rdata == '0 &&
      turnaround_length == STC_TRN_RESET)
    else $error("scan variant shows content");
  chk_lc_res_bits: assert property (
    ce && hit_lc && !req.write |=>
      resp.rdata[31:STC_LC_RES0_LSB] == '0)
    else $error("link control reserved bits set");
  chk_gap_start: assert property (
    ce && trn_start && !trn_active |=> trn_active && !trn_done)
    else $error("turnaround gap did not start");
  chk_gap_end: assert property (
    trn_active && !$past(trn_active) |-> !trn_done [*2])
    else $error("turnaround gap ended too soon");

  cov_len_write: cover property (ce && lc_wr && VARIABLE_TRN);
  cov_gap_done: cover property (trn_done && len_q == 2'h3);
  cov_ident_read: cover property (ce && hit_id && !req.write);
  cov_fixed_err: cover property (ce && fixed_err);

endmodule
`default_nettype wire

// file: testbench/stc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module stc_host_model
(
  input wire logic run,
  output logic link_clk
);
  // Clock idles low between frames; odd offset keeps phase unrelated
  initial
  begin
    link_clk = 1'b0;
    forever
    begin
      wait (run);
      #17 link_clk = 1'b1;
      #32 link_clk = 1'b0;
      #15;
    end
  end
endmodule
`default_nettype wire

// file: testbench/stc_link_turnaround_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module stc_link_turnaround_control_bench
  import stc_pkg::*;
;
  logic clk, reset, ce, link_clk, trn_start, run;
  logic trn_active, trn_done;
  logic [1:0] turnaround_length, code;
  logic [7:0] lfsr, r;
  logic [31:0] wd, id_exp;
  stc_req_t req;
  stc_resp_t resp, rsp;
  stc_resp_t fix_resp, scan_resp, fsp, ssp;
  logic [1:0] fix_len, scan_len;
  int failures, num_checks, edges, cyc;

  stc_link_turnaround_control #(.INSTANCE_NUM(4'h5)) dut_u
  (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .link_clk(link_clk),
    .req(req),
    .trn_start(trn_start),
    .resp(resp),
    .turnaround_length(turnaround_length),
    .trn_active(trn_active),
    .trn_done(trn_done)
  );

  stc_link_turnaround_control #(.VARIABLE_TRN(1'b0)) fix_u
  (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .link_clk(link_clk),
    .req(req),
    .trn_start(trn_start),
    .resp(fix_resp),
    .turnaround_length(fix_len),
    .trn_active(),
    .trn_done()
  );

  stc_link_turnaround_control #(.SCAN_VARIANT(1'b1), .ARCH_TWO(1'b0)) scan_u
  (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .link_clk(link_clk),
    .req(req),
    .trn_start(trn_start),
    .resp(scan_resp),
    .turnaround_length(scan_len),
    .trn_active(),
    .trn_done()
  );

  stc_host_model host_u
  (
    .run(run),
    .link_clk(link_clk)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge link_clk)
    edges++;

  // Cut a hang short long after the last gap should have ended
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  function automatic logic [31:0] lc_exp(input logic [1:0] n);
    return {22'h0, n, 8'h40};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [3:0] o,
                     input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    #1 req = '{1'b1, w, o, b, d};
    @(posedge clk);
    #1 req = '0;
    rsp = resp;
    fsp = fix_resp;
    ssp = scan_resp;
    chk(rsp.valid, 1'b1);
  endtask

  task automatic gap(input logic [1:0] n);
    int t;
    t = 0;
    edges = 0;
    @(posedge clk);
    #1 trn_start = 1'b1;
    @(posedge clk);
    #1 run = 1'b1;
    chk(trn_active, 1'b1);
    // Held one cycle more: a start while active must be ignored
    @(posedge clk);
    #1 trn_start = 1'b0;
    chk(trn_active, 1'b1);
    while (trn_done !== 1'b1 && t < 400)
    begin
      @(posedge clk);
      #1 t++;
    end
    run = 1'b0;
    chk({trn_done, trn_active}, 2'b10);
    chk(edges, n + 3'd1);
  endtask

  task automatic summarize();
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    req = '0;
    trn_start = 1'b0;
    run = 1'b0;
    lfsr = 8'h5c;
    id_exp = {4'h5, 24'h0, 4'h1};
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    chk(turnaround_length, 2'h0);
    acc(1'b0, 4'h4, 4'h1, 32'h0);
    chk(rsp.rdata, lc_exp(2'h0));
    acc(1'b0, 4'h4, 4'h3, 32'h0);
    chk(rsp.hit, 1'b1);
    chk(rsp.rdata, id_exp);
    chk(ssp.hit, 1'b0);
    chk(ssp.rdata, 32'h0);
    acc(1'b1, 4'h4, 4'h3, {rnd(), rnd(), rnd(), rnd()});
    acc(1'b0, 4'h4, 4'h3, 32'h0);
    chk(rsp.rdata, id_exp);
    for (int i = 0; i < 4; i++)
    begin
      code = 2'(i) ^ 2'h2;
      wd = {rnd(), rnd(), rnd(), rnd()};
      wd[9:8] = code;
      acc(1'b1, 4'h4, 4'h1, wd);
      chk({rsp.proto_err, turnaround_length}, {1'b0, code});
      chk({fsp.proto_err, fix_len}, {code != 2'h0, 2'h0});
      chk(ssp.rdata, 32'h0);
      chk(scan_len, 2'h0);
      r = rnd();
      acc(1'b1, r[3:0], {r[6:4], 1'b0}, ~wd);
      chk({rsp.hit, turnaround_length}, {1'b0, code});
      chk(rsp.rdata, 32'h0);
      acc(1'b0, 4'h4, 4'h1, 32'h0);
      chk(rsp.rdata, lc_exp(code));
      chk(fsp.rdata, lc_exp(2'h0));
      chk(ssp.rdata, 32'h0);
      gap(code);
    end
    // Write while ce is low must not land
    @(posedge clk);
    #1 ce = 1'b0;
    req = '{1'b1, 1'b1, 4'h4, 4'h1, 32'h300};
    @(posedge clk);
    #1 req = '0;
    ce = 1'b1;
    chk(turnaround_length, code);
    reset = 1'b1;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    chk(turnaround_length, 2'h0);
    acc(1'b0, 4'h4, 4'h1, 32'h0);
    chk(rsp.rdata, lc_exp(2'h0));
    summarize();
  end
endmodule
`default_nettype wire
